// *** rtl/ssd_pkg.sv ***
/*
 * Constants shared by the serial sink driver design files.
 * Assumes a single core clock; all pin inputs are asynchronous to it.
 */
package ssd_pkg;

    // ------------------------------------------------------------
    // Widths and depths
    // ------------------------------------------------------------
    localparam int unsigned SSD_SHIFT_W    = 8;
    localparam int unsigned SSD_FIFO_W     = 1;
    localparam int unsigned SSD_FIFO_DEPTH = 4;
    localparam int unsigned SSD_SYNC_W     = 5;

    // ------------------------------------------------------------
    // Bit positions in the synchronised pin vector
    // ------------------------------------------------------------
    localparam int unsigned SSD_IDX_SCLK   = 0;
    localparam int unsigned SSD_IDX_SDATA  = 1;
    localparam int unsigned SSD_IDX_STROBE = 2;
    localparam int unsigned SSD_IDX_OE_N   = 3;
    localparam int unsigned SSD_IDX_HALF   = 4;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [SSD_SYNC_W-1:0]  SSD_SYNC_RST  = 5'h08;
    localparam logic [SSD_SHIFT_W-1:0] SSD_SHREG_RST = 8'h00;
    localparam logic [SSD_SHIFT_W-1:0] SSD_LATCH_RST = 8'h00;
    localparam logic [SSD_SHIFT_W-1:0] SSD_SINK_OFF  = 8'h00;

endpackage

// *** rtl/ssd_stream_if.sv ***
/*
 * Valid/ready stream carrier between the driver core and its FIFO.
 * Assumes both ends run on the same clock.
 */
`timescale 1ns/1ps
`default_nettype none

interface ssd_stream_if #(
    parameter int unsigned W = 1
) ();
    logic         valid;
    logic         ready;
    logic [W-1:0] data;

    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface

`default_nettype wire

// *** rtl/ssd_pin_sync.sv ***
/*
 * Three-stage synchroniser for asynchronous pins with agreement filter.
 * Assumes pins are asynchronous to clk_i; output changes only when
 * the second and third stages agree.
 */
`timescale 1ns/1ps
`default_nettype none

module ssd_pin_sync #(
    parameter int unsigned  W   = 1,
    parameter logic [W-1:0] RST = '0
) (
    input  wire logic         clk_i,
    input  wire logic         arst_n_i,
    input  wire logic [W-1:0] pin_i,
    output logic      [W-1:0] lvl_o
);

    logic [W-1:0] s1_r;
    logic [W-1:0] s2_r;
    logic [W-1:0] s3_r;

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            s1_r <= RST;
            s2_r <= RST;
            s3_r <= RST;
        end else begin
            s1_r <= pin_i;
            s2_r <= s1_r;
            s3_r <= s2_r;
        end
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            lvl_o <= RST;
        end else begin
            lvl_o <= (s2_r & ~(s2_r ^ s3_r)) | (lvl_o & (s2_r ^ s3_r));
        end
    end

endmodule

`default_nettype wire

// *** rtl/ssd_fifo.sv ***
/*
 * Small synchronous FIFO with valid/ready on both sides.
 * Assumes one clock; full and empty follow the occupancy count.
 */
`timescale 1ns/1ps
`default_nettype none

module ssd_fifo #(
    parameter int unsigned W     = 1,
    parameter int unsigned DEPTH = 4
) (
    input  wire logic   clk_i,
    input  wire logic   arst_n_i,
    ssd_stream_if.snk   wr,
    ssd_stream_if.src   rd
);

    localparam int unsigned AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int unsigned CW = $clog2(DEPTH + 1);
    localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);
    localparam logic [CW-1:0] FULL = CW'(DEPTH);

    logic [W-1:0]  mem_r [DEPTH];
    logic [AW-1:0] wp_r;
    logic [AW-1:0] rp_r;
    logic [CW-1:0] cnt_r;
    logic          push;
    logic          pop;

    assign wr.ready = (cnt_r != FULL);
    assign rd.valid = (cnt_r != '0);
    assign rd.data  = mem_r[rp_r];
    assign push     = wr.valid && wr.ready;
    assign pop      = rd.valid && rd.ready;

    always_ff @(posedge clk_i) begin
        if (push) begin
            mem_r[wp_r] <= wr.data;
        end
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            wp_r <= '0;
            rp_r <= '0;
        end else begin
            if (push) begin
                wp_r <= (wp_r == LAST) ? '0 : wp_r + 1'b1;
            end
            if (pop) begin
                rp_r <= (rp_r == LAST) ? '0 : rp_r + 1'b1;
            end
        end
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            cnt_r <= '0;
        end else if (push && !pop) begin
            cnt_r <= cnt_r + 1'b1;
        end else if (pop && !push) begin
            cnt_r <= cnt_r - 1'b1;
        end
    end

endmodule

`default_nettype wire

// *** rtl/ssd_top.sv ***
/*
 * Serial-in latched sink driver core: shift register, level latches,
 * blanking, current select and two cascade outputs.
 * Assumes all pins are asynchronous to CORE_CLK_I and the serial clock
 * is slow enough for several core cycles per phase.
 */
// Contract
// R1: Shift one stage per serial clock rise.
// R2: Serial input enters first stage at rise.
// R3: Strobe high loads latches, low holds.
// R4: Eight sink outputs, one latch bit each.
// R5: Enable high blanks all sinks, low enables.
// R6: Select low full current, high half.
// R7: First cascade output updates on rise.
// R8: Second cascade output updates on fall.
// R9: Latches follow shift data while strobe high.
// R10: Enable never changes latch contents.
// R11: Host blanks outputs while shifting if transparent.
// R12: Both cascades carry last stage, half-period apart.
// R13: Host shifts eight bits per device first.
`timescale 1ns/1ps
`default_nettype none

module ssd_top (
    input  wire logic                            CORE_CLK_I,
    input  wire logic                            ARST_N_I,
    input  wire logic                            SCLK_I,
    input  wire logic                            SDATA_I,
    input  wire logic                            STROBE_I,
    input  wire logic                            OE_N_I,
    input  wire logic                            HALF_CUR_I,
    output logic      [ssd_pkg::SSD_SHIFT_W-1:0] SINK_ON_O,
    output logic                                 HALF_CUR_O,
    output logic                                 CASC_RISE_O,
    output logic                                 CASC_FALL_O,
    output logic                                 OVERRUN_O
);

    import ssd_pkg::*;

    // ------------------------------------------------------------
    // Pin synchronisation and serial clock edges
    // ------------------------------------------------------------
    function automatic logic edge_seen(input logic prev, input logic cur, input logic to_high);
        edge_seen = (prev != cur) && (cur == to_high);
    endfunction

    logic [SSD_SYNC_W-1:0] pin_vec;
    logic [SSD_SYNC_W-1:0] lvl;
    logic                  sclk_prev_r;
    logic                  sclk_rise;
    logic                  sclk_fall;

    assign pin_vec = {HALF_CUR_I, OE_N_I, STROBE_I, SDATA_I, SCLK_I};

    ssd_pin_sync #(
        .W   (SSD_SYNC_W),
        .RST (SSD_SYNC_RST)
    ) u_sync (
        .clk_i    (CORE_CLK_I),
        .arst_n_i (ARST_N_I),
        .pin_i    (pin_vec),
        .lvl_o    (lvl)
    );

    always_ff @(posedge CORE_CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            sclk_prev_r <= 1'b0;
        end else begin
            sclk_prev_r <= lvl[SSD_IDX_SCLK];
        end
    end

    assign sclk_rise = edge_seen(sclk_prev_r, lvl[SSD_IDX_SCLK], 1'b1);
    assign sclk_fall = edge_seen(sclk_prev_r, lvl[SSD_IDX_SCLK], 1'b0);

    // ------------------------------------------------------------
    // Sampled bit FIFO
    // ------------------------------------------------------------
    ssd_stream_if #(.W(SSD_FIFO_W)) s_in ();
    ssd_stream_if #(.W(SSD_FIFO_W)) s_out ();

    assign s_in.valid  = sclk_rise;
    assign s_in.data   = lvl[SSD_IDX_SDATA]; // R2
    assign s_out.ready = !sclk_fall;

    ssd_fifo #(
        .W     (SSD_FIFO_W),
        .DEPTH (SSD_FIFO_DEPTH)
    ) u_fifo (
        .clk_i    (CORE_CLK_I),
        .arst_n_i (ARST_N_I),
        .wr       (s_in),
        .rd       (s_out)
    );

    always_ff @(posedge CORE_CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            OVERRUN_O <= 1'b0;
        end else if (s_in.valid && !s_in.ready) begin
            OVERRUN_O <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // Shift register and cascade outputs
    // ------------------------------------------------------------
    logic [SSD_SHIFT_W-1:0] shreg_r;
    logic [SSD_SHIFT_W-1:0] shreg_nxt;
    logic                   shift;

    assign shift     = s_out.valid && s_out.ready;
    assign shreg_nxt = {shreg_r[SSD_SHIFT_W-2:0], s_out.data}; // R1 R2

    always_ff @(posedge CORE_CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            shreg_r <= SSD_SHREG_RST;
        end else if (shift) begin
            shreg_r <= shreg_nxt; // R1
        end
    end

    always_ff @(posedge CORE_CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            CASC_RISE_O <= 1'b0;
        end else if (shift) begin
            CASC_RISE_O <= shreg_nxt[SSD_SHIFT_W-1]; // R7 R12
        end
    end

    always_ff @(posedge CORE_CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            CASC_FALL_O <= 1'b0;
        end else if (sclk_fall) begin
            CASC_FALL_O <= shreg_r[SSD_SHIFT_W-1]; // R8 R12
        end
    end

    // ------------------------------------------------------------
    // Latches, blanking and current select
    // ------------------------------------------------------------
    logic [SSD_SHIFT_W-1:0] latch_r;

    always_ff @(posedge CORE_CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            latch_r <= SSD_LATCH_RST;
        end else if (lvl[SSD_IDX_STROBE]) begin
            latch_r <= shreg_r; // R3 R9 R10
        end
    end

    always_ff @(posedge CORE_CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            SINK_ON_O <= SSD_SINK_OFF;
        end else if (lvl[SSD_IDX_OE_N]) begin
            SINK_ON_O <= SSD_SINK_OFF; // R5
        end else begin
            SINK_ON_O <= latch_r; // R4 R5
        end
    end

    always_ff @(posedge CORE_CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            HALF_CUR_O <= 1'b0;
        end else begin
            HALF_CUR_O <= lvl[SSD_IDX_HALF]; // R6
        end
    end

endmodule

`default_nettype wire

// *** tb/ssd_host.sv ***
/*
 * Host model that drives the serial, strobe, enable and select pins.
 * Assumes the bench calls its tasks; pins change 1 ns after a clock rise.
 */
`timescale 1ns/1ps
`default_nettype none

module ssd_host (
    input  wire logic clk_i,
    output logic      sclk_o,
    output logic      sdata_o,
    output logic      strobe_o,
    output logic      oe_n_o,
    output logic      half_o
);
    initial begin
        sclk_o   = 1'b0;
        sdata_o  = 1'b0;
        strobe_o = 1'b0;
        oe_n_o   = 1'b1;
        half_o   = 1'b0;
    end

    task automatic ctl(input logic s, input logic o, input logic h);
        @(posedge clk_i);
        #1;
        strobe_o = s;
        oe_n_o   = o;
        half_o   = h;
        // Each level stands six core cycles so the pin filter sees it.
        repeat (5) @(posedge clk_i);
    endtask

    // One bit: data set, clock high, clock low, then data held no longer.
    task automatic bit_out(input logic b);
        @(posedge clk_i);
        #1;
        sdata_o = b;
        repeat (5) @(posedge clk_i);
        #1;
        sclk_o = 1'b1;
        repeat (10) @(posedge clk_i);
        #1;
        sclk_o = 1'b0;
        repeat (10) @(posedge clk_i);
        #1;
        sdata_o = ~b;
    endtask
endmodule

`default_nettype wire

// *** tb/ssd_top_asserts.sv ***
/*
 * Concurrent checks on the driver's ports.
 * Assumes serial clock phases of at least ten core cycles.
 */
`timescale 1ns/1ps
`default_nettype none

module ssd_top_asserts
    import ssd_pkg::*;
(
    input wire logic                            CORE_CLK_I,
    input wire logic                            ARST_N_I,
    input wire logic                            SCLK_I,
    input wire logic                            STROBE_I,
    input wire logic                            OE_N_I,
    input wire logic                            HALF_CUR_I,
    input wire logic [ssd_pkg::SSD_SHIFT_W-1:0] SINK_ON_O,
    input wire logic                            HALF_CUR_O,
    input wire logic                            CASC_RISE_O,
    input wire logic                            CASC_FALL_O
);
    default clocking cb @(posedge CORE_CLK_I);
    endclocking
    default disable iff (!ARST_N_I);

    blank_all_a: assert property (OE_N_I [*6] |-> SINK_ON_O == 8'h00)
        else $error("sinks on while blanked");
    drive_gate_a: assert property (SINK_ON_O != 8'h00 |-> !$past(OE_N_I, 5))
        else $error("sinks on without enable");
    half_sel_a: assert property ($stable(HALF_CUR_I) [*6] |-> HALF_CUR_O == HALF_CUR_I)
        else $error("current select wrong");
    hold_latch_a: assert property ((!STROBE_I && !OE_N_I) [*8] |-> $stable(SINK_ON_O))
        else $error("latch changed with strobe low");
    latch_follow_a: assert property ((STROBE_I && !OE_N_I) [*8]
        |-> SINK_ON_O[7] == $past(CASC_RISE_O, 2)) else $error("latch not following");
    rise_edge_a: assert property ($changed(CASC_RISE_O) |-> SCLK_I)
        else $error("rise cascade moved with clock low");
    fall_edge_a: assert property ($changed(CASC_FALL_O) |-> !SCLK_I)
        else $error("fall cascade moved with clock high");
    fall_pair_a: assert property ($changed(CASC_FALL_O) |-> CASC_FALL_O == CASC_RISE_O)
        else $error("cascades disagree");
endmodule

bind ssd_top ssd_top_asserts u_chk (
    .CORE_CLK_I (CORE_CLK_I),
    .ARST_N_I   (ARST_N_I),
    .SCLK_I     (SCLK_I),
    .STROBE_I   (STROBE_I),
    .OE_N_I     (OE_N_I),
    .HALF_CUR_I (HALF_CUR_I),
    .SINK_ON_O  (SINK_ON_O),
    .HALF_CUR_O (HALF_CUR_O),
    .CASC_RISE_O(CASC_RISE_O),
    .CASC_FALL_O(CASC_FALL_O)
);

`default_nettype wire

// *** tb/testbench.sv ***
/*
 * Self-checking bench for the serial sink driver.
 * Assumes the host model and the bound checker.
 */
`timescale 1ns/1ps
`default_nettype none

`define CHK(n, e, s) begin comparisons++; if ((s) !== (e)) begin fails++; \
    $display("[ERR] %s expected %h seen %h", n, e, s); end end

module testbench;
    import ssd_pkg::*;
    logic                   clk;
    logic                   arst_n;
    wire logic              sclk, sdata, strobe, oe_n, half;
    logic [SSD_SHIFT_W-1:0] sink;
    logic [SSD_SHIFT_W-1:0] sh_exp;
    logic                   half_o, casc_r, casc_f, ovr;
    int                     fails = 0;
    int                     comparisons = 0;

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    ssd_host host (.clk_i(clk), .sclk_o(sclk), .sdata_o(sdata), .strobe_o(strobe),
        .oe_n_o(oe_n), .half_o(half));
    ssd_top uut (.CORE_CLK_I(clk), .ARST_N_I(arst_n), .SCLK_I(sclk), .SDATA_I(sdata),
        .STROBE_I(strobe), .OE_N_I(oe_n), .HALF_CUR_I(half), .SINK_ON_O(sink),
        .HALF_CUR_O(half_o), .CASC_RISE_O(casc_r), .CASC_FALL_O(casc_f), .OVERRUN_O(ovr));

    // --------------------------------------------------------------
    // Scenario tasks
    // --------------------------------------------------------------
    task automatic close_out;
        $display("comparisons %0d mismatches %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    task automatic settle;
        repeat (8) @(posedge clk);
        #1;
    endtask

    task automatic shift_byte(input logic [7:0] v);
        for (int i = 7; i >= 0; i--) begin
            host.bit_out(v[i]);
            sh_exp = {sh_exp[6:0], v[i]};
            `CHK("casc_rise", sh_exp[7], casc_r)
            `CHK("casc_fall", sh_exp[7], casc_f)
        end
    endtask

    task automatic t_load;
        host.ctl(1'b0, 1'b1, 1'b0);
        shift_byte(8'ha5);
        host.ctl(1'b1, 1'b1, 1'b0);
        host.ctl(1'b0, 1'b0, 1'b0);
        settle();
        `CHK("sink", 8'ha5, sink)
    endtask

    task automatic t_hold_blank;
        shift_byte(8'h3c);
        `CHK("sink", 8'ha5, sink)
        host.ctl(1'b1, 1'b0, 1'b0);
        host.ctl(1'b0, 1'b1, 1'b0);
        settle();
        `CHK("sink", 8'h00, sink)
        host.ctl(1'b0, 1'b0, 1'b1);
        settle();
        `CHK("sink", 8'h3c, sink)
        `CHK("half", 1'b1, half_o)
        host.ctl(1'b0, 1'b0, 1'b0);
        settle();
        `CHK("half", 1'b0, half_o)
    endtask

    task automatic t_transparent;
        host.ctl(1'b1, 1'b1, 1'b0);
        shift_byte(8'h0f);
        host.ctl(1'b1, 1'b0, 1'b0);
        settle();
        `CHK("sink", 8'h0f, sink)
        host.ctl(1'b0, 1'b0, 1'b0);
        shift_byte(8'h81);
        shift_byte(8'h7e);
        `CHK("sink", 8'h0f, sink)
        `CHK("overrun", 1'b0, ovr)
    endtask

    initial begin
        repeat (3000) @(posedge clk);
        fails++;
        close_out();
    end

    initial begin
        arst_n = 1'b0;
        sh_exp = 8'h00;
        repeat (16) @(posedge clk);
        #1;
        arst_n = 1'b1;
        settle();
        `CHK("sink", 8'h00, sink)
        t_load();
        t_hold_blank();
        t_transparent();
        close_out();
    end
endmodule

`default_nettype wire
